// File: rtl/timer_pwm_capture_gated.sv
// What this block does
// - PWM mode counts up; count equal to match inverts the output.
// - PWM mode at reload raises interrupt, restarts count at 0001H, keeps counting.
// - polarity one: output starts high, low on match, high again at reload.
// - polarity zero: output starts low, high on match, low again at reload.
// - PWM start count applies to the first pass only; later passes begin at 0001H.
// - the timer counts the prescaled system clock, not an external signal.
// - capture mode copies the count into the PWM byte registers on an edge.
// - in capture mode polarity picks rising or falling input edges.
// - capture raises interrupt, sets capture-cause flag, count left untouched.
// - capture mode at reload raises interrupt, clears flag, keeps counting.
// - gated mode start count applies to first pass; then restarts at 0001H.
// - gated mode interrupts on deassertion and reload; a field can pick one.
// - mode selector {high bit, three low bits}: 0011 PWM, 0100 capture.
// - prescaler divides by two to a 3-bit exponent; reset while disabled.
`timescale 1ns/100ps

module timer_pwm_capture_gated #(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timerIn,
  output logic                   timerOut,
  output logic                   timerIrq
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [15:0] pwm;
    logic        modeHi;
    logic [1:0]  intSrc;
    logic        capFlag;
    logic        enable;
    logic        pol;
    logic [2:0]  presExp;
    logic [2:0]  modeLo;
    logic [6:0]  pre;
    logic        outLvl;
    logic        tinPrev;
    logic [7:0]  lowHold;
    logic [31:0] rdata;
    logic        slvErr;
    logic        irq;
  } state_s;

  state_s stateReg;
  state_s stateNext;

  logic [3:0]        mode;
  logic [2:0]        idx;
  logic              addrOk;
  logic              setup;
  logic              access;
  logic [6:0]        preMask;
  logic              tick;
  logic              atReload;
  logic [15:0]       cntStep;
  logic              riseEdge;
  logic              fallEdge;
  logic              capEdge;
  logic [7:0]        rdByte;

  assign mode    = {stateReg.modeHi, stateReg.modeLo};
  assign idx     = paddr[4:2];
  assign addrOk  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign prdata  = stateReg.rdata;
  assign pslverr = stateReg.slvErr;
  assign timerIrq = stateReg.irq;

  // output idles at its starting level, so enabling never glitches the pin
  assign timerOut = stateReg.enable ? stateReg.outLvl : stateReg.pol;

  // divide by 2**exp: tick when the low exp bits of the free counter are all ones
  assign preMask  = 7'((8'h01 << stateReg.presExp) - 8'h01);
  assign tick     = stateReg.enable && ((stateReg.pre & preMask) == preMask);
  assign atReload = (stateReg.cnt == stateReg.reload);
  assign cntStep  = atReload ? timer_pwm_capture_gated_pkg::CNT_RESTART
                             : 16'(stateReg.cnt + 16'h0001);
  assign riseEdge = !stateReg.tinPrev && timerIn;
  assign fallEdge = stateReg.tinPrev && !timerIn;
  assign capEdge  = stateReg.pol ? riseEdge : fallEdge;

  always_comb
  begin
    rdByte = 8'h00;
    case (idx)
      timer_pwm_capture_gated_pkg::IDX_CNT_HI:
        rdByte = stateReg.cnt[15:8];
      timer_pwm_capture_gated_pkg::IDX_CNT_LO:
        rdByte = stateReg.enable ? stateReg.lowHold : stateReg.cnt[7:0];
      timer_pwm_capture_gated_pkg::IDX_RELOAD_HI:
        rdByte = stateReg.reload[15:8];
      timer_pwm_capture_gated_pkg::IDX_RELOAD_LO:
        rdByte = stateReg.reload[7:0];
      timer_pwm_capture_gated_pkg::IDX_PWM_HI:
        rdByte = stateReg.pwm[15:8];
      timer_pwm_capture_gated_pkg::IDX_PWM_LO:
        rdByte = stateReg.pwm[7:0];
      timer_pwm_capture_gated_pkg::IDX_CTL0:
      begin
        rdByte[timer_pwm_capture_gated_pkg::CTL0_MODE_HI_BIT] = stateReg.modeHi;
        rdByte[timer_pwm_capture_gated_pkg::CTL0_INT_SRC_MSB:
               timer_pwm_capture_gated_pkg::CTL0_INT_SRC_LSB] = stateReg.intSrc;
        rdByte[timer_pwm_capture_gated_pkg::CTL0_CAP_FLAG_BIT] = stateReg.capFlag;
      end
      timer_pwm_capture_gated_pkg::IDX_CTL1:
        rdByte = {stateReg.enable, stateReg.pol, stateReg.presExp, stateReg.modeLo};
      default:
        rdByte = 8'h00;
    endcase
  end

  always_comb
  begin
    stateNext         = stateReg;
    stateNext.irq     = 1'b0;
    stateNext.tinPrev = timerIn;

    // free prescaler, held at zero while disabled so each start divides cleanly
    if (stateReg.enable)
    begin
      stateNext.pre = 7'(stateReg.pre + 7'h01);
    end
    else
    begin
      stateNext.pre = 7'h00;
    end

    if (stateReg.enable)
    begin
      case (mode)
        timer_pwm_capture_gated_pkg::MODE_PWM_SINGLE:
        begin
          if (tick)
          begin
            stateNext.cnt = cntStep;
            if (atReload)
            begin
              stateNext.irq    = 1'b1;
              stateNext.outLvl = stateReg.pol;
            end
            else if (cntStep == stateReg.pwm)
            begin
              stateNext.outLvl = !stateReg.outLvl;
            end
          end
        end
        timer_pwm_capture_gated_pkg::MODE_CAPTURE:
        begin
          if (tick)
          begin
            stateNext.cnt = cntStep;
            if (atReload)
            begin
              stateNext.irq     = 1'b1;
              stateNext.capFlag = 1'b0;
            end
          end
          // capture after the reload clear, so a same-cycle capture wins the flag
          if (capEdge)
          begin
            stateNext.pwm     = stateReg.cnt;
            stateNext.irq     = 1'b1;
            stateNext.capFlag = 1'b1;
          end
        end
        timer_pwm_capture_gated_pkg::MODE_GATED:
        begin
          if (tick && timerIn)
          begin
            stateNext.cnt = cntStep;
            if (atReload &&
                (stateReg.intSrc != timer_pwm_capture_gated_pkg::INT_SRC_DEASSERT_ONLY))
            begin
              stateNext.irq = 1'b1;
            end
          end
          if (fallEdge &&
              (stateReg.intSrc != timer_pwm_capture_gated_pkg::INT_SRC_RELOAD_ONLY))
          begin
            stateNext.irq = 1'b1;
          end
        end
        default:
        begin
          stateNext.cnt = stateReg.cnt;
        end
      endcase
    end
    else
    begin
      stateNext.outLvl = stateReg.pol;
    end

    // apb: read data and error are registered in the setup cycle
    if (setup)
    begin
      stateNext.slvErr = !addrOk;
      stateNext.rdata  = addrOk ? {24'h000000, rdByte} : 32'h00000000;
    end

    if (access && !pwrite && addrOk && (idx == timer_pwm_capture_gated_pkg::IDX_CNT_HI))
    begin
      // reading the high byte freezes the low byte in the access cycle, one cycle after the high byte was sampled in setup
      stateNext.lowHold = stateReg.cnt[7:0];
    end

    // software writes override hardware updates in the same cycle
    if (access && pwrite && addrOk && pstrb[0])
    begin
      case (idx)
        timer_pwm_capture_gated_pkg::IDX_CNT_HI:
          stateNext.cnt[15:8] = pwdata[7:0];
        timer_pwm_capture_gated_pkg::IDX_CNT_LO:
          stateNext.cnt[7:0] = pwdata[7:0];
        timer_pwm_capture_gated_pkg::IDX_RELOAD_HI:
          stateNext.reload[15:8] = pwdata[7:0];
        timer_pwm_capture_gated_pkg::IDX_RELOAD_LO:
          stateNext.reload[7:0] = pwdata[7:0];
        timer_pwm_capture_gated_pkg::IDX_PWM_HI:
          stateNext.pwm[15:8] = pwdata[7:0];
        timer_pwm_capture_gated_pkg::IDX_PWM_LO:
          stateNext.pwm[7:0] = pwdata[7:0];
        timer_pwm_capture_gated_pkg::IDX_CTL0:
        begin
          // the capture-cause flag is hardware owned and ignores writes
          stateNext.modeHi = pwdata[timer_pwm_capture_gated_pkg::CTL0_MODE_HI_BIT];
          stateNext.intSrc = pwdata[timer_pwm_capture_gated_pkg::CTL0_INT_SRC_MSB:
                                    timer_pwm_capture_gated_pkg::CTL0_INT_SRC_LSB];
        end
        timer_pwm_capture_gated_pkg::IDX_CTL1:
        begin
          stateNext.enable  = pwdata[timer_pwm_capture_gated_pkg::CTL1_ENABLE_BIT];
          stateNext.pol     = pwdata[timer_pwm_capture_gated_pkg::CTL1_POL_BIT];
          stateNext.presExp = pwdata[timer_pwm_capture_gated_pkg::CTL1_PRESCALE_EXPONENT_MSB:
                                     timer_pwm_capture_gated_pkg::CTL1_PRESCALE_EXPONENT_LSB];
          stateNext.modeLo  = pwdata[timer_pwm_capture_gated_pkg::CTL1_MODE_LO_MSB:0];
        end
        default:
          stateNext.cnt = stateNext.cnt;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stateReg         <= '0;
      stateReg.cnt     <= timer_pwm_capture_gated_pkg::CNT_RESET;
      stateReg.reload  <= timer_pwm_capture_gated_pkg::RELOAD_RESET;
      stateReg.pwm     <= timer_pwm_capture_gated_pkg::PWM_RESET;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

endmodule : timer_pwm_capture_gated

// File: rtl/timer_pwm_capture_gated_pkg.sv
package timer_pwm_capture_gated_pkg;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_CNT_HI    = 3'h0;
  localparam logic [2:0] IDX_CNT_LO    = 3'h1;
  localparam logic [2:0] IDX_RELOAD_HI = 3'h2;
  localparam logic [2:0] IDX_RELOAD_LO = 3'h3;
  localparam logic [2:0] IDX_PWM_HI    = 3'h4;
  localparam logic [2:0] IDX_PWM_LO    = 3'h5;
  localparam logic [2:0] IDX_CTL0      = 3'h6;
  localparam logic [2:0] IDX_CTL1      = 3'h7;

  // timer_control_zero fields
  localparam int CTL0_MODE_HI_BIT  = 7;
  localparam int CTL0_INT_SRC_MSB  = 4;
  localparam int CTL0_INT_SRC_LSB  = 3;
  localparam int CTL0_CAP_FLAG_BIT = 1;

  // timer_control_one fields
  localparam int CTL1_ENABLE_BIT  = 7;
  localparam int CTL1_POL_BIT     = 6;
  localparam int CTL1_PRESCALE_EXPONENT_MSB    = 5;
  localparam int CTL1_PRESCALE_EXPONENT_LSB    = 3;
  localparam int CTL1_MODE_LO_MSB = 2;

  // reset values and the count restart value
  localparam logic [15:0] CNT_RESET    = 16'h0001;
  localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
  localparam logic [15:0] PWM_RESET    = 16'h0000;
  localparam logic [15:0] CNT_RESTART  = 16'h0001;

  typedef enum logic [3:0] {
    MODE_PWM_SINGLE = 4'h3,
    MODE_CAPTURE    = 4'h4,
    MODE_GATED      = 4'h6
  } mode_e;

  // interrupt_source_select encodings
  localparam logic [1:0] INT_SRC_DEASSERT_ONLY = 2'h2;
  localparam logic [1:0] INT_SRC_RELOAD_ONLY   = 2'h3;

endpackage : timer_pwm_capture_gated_pkg

// File: verif/timer_input_source.sv
`timescale 1ns/100ps
module timer_input_source (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic [7:0] holdLen,
  output logic            timerIn
);
  logic [7:0] leftReg;
  // holds the pin high for holdLen clocks after a go request
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      {timerIn, leftReg} <= 9'h000;
    else if (go)
      {timerIn, leftReg} <= {1'b1, holdLen};
    else if (leftReg > 8'h01)
      leftReg <= leftReg - 8'h01;
    else
      timerIn <= 1'b0;
  end
endmodule : timer_input_source

// File: verif/timer_pwm_capture_gated_checker.sv
`timescale 1ns/100ps
module timer_pwm_capture_gated_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              timerIn,
  input wire logic              timerOut,
  input wire logic              timerIrq
);
  logic [7:0] ctl0Reg;
  logic [7:0] ctl1Reg;
  wire        okAddr = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:5] == '0;
  wire        wrHit  = psel && penable && pwrite && pready && pstrb[0] && okAddr;
  wire [3:0]  mode   = {ctl0Reg[7], ctl1Reg[2:0]};
  wire        en     = ctl1Reg[7];
  wire        pol    = ctl1Reg[6];
  // shadow of the control bytes, so mode and polarity are known from the bus alone
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      {ctl0Reg, ctl1Reg} <= 16'h0000;
    else if (wrHit && paddr[4:2] == 3'h6)
      ctl0Reg <= pwdata[7:0];
    else if (wrHit && paddr[4:2] == 3'h7)
      ctl1Reg <= pwdata[7:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_rdata_upper: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_err_unmapped: assert property (psel && !penable && !okAddr |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (psel && !penable && okAddr |=> !pslverr)
    else $error("mapped access refused");
  chk_out_idle: assert property (!en |-> timerOut == pol)
    else $error("idle output not at polarity");
  chk_pwm_return: assert property (en && mode == 4'h3 && timerIrq |-> timerOut == pol)
    else $error("output not restored at reload");
  chk_cap_edge: assert property (en && mode == 4'h4 && (pol ? $rose(timerIn) : $fell(timerIn)) |=> timerIrq)
    else $error("capture edge without interrupt");
  chk_gate_fall: assert property (en && mode == 4'h6 && ctl0Reg[4:3] != 2'h3 && $fell(timerIn) |=> timerIrq)
    else $error("gate release without interrupt");
  cover property (en && mode == 4'h3 && timerIrq);
  cover property (en && mode == 4'h4 && timerIrq);
  cover property (en && mode == 4'h6 && $fell(timerIn));
endmodule : timer_pwm_capture_gated_checker

bind timer_pwm_capture_gated timer_pwm_capture_gated_checker #(.ADDR_W(ADDR_W)) i_timer_pwm_capture_gated_checker (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerIn(timerIn), .timerOut(timerOut),
  .timerIrq(timerIrq));

// File: verif/timer_pwm_capture_gated_tb.sv
`timescale 1ns/100ps
module timer_pwm_capture_gated_tb;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        go = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  holdLen = 8'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, timerIn, timerOut, timerIrq, err;
  int          cyc = 0, hiCyc = 0, n_mismatch = 0, check_count = 0, enCyc;
  int          irqQ[$], hiQ[$];
  logic [7:0]  rv [8] = '{8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  initial forever #5 mclk = ~mclk;
  timer_pwm_capture_gated i_timer_pwm_capture_gated (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerIn(timerIn), .timerOut(timerOut), .timerIrq(timerIrq));
  // the source stands where the routed input pin would be
  timer_input_source i_timer_input_source (.mclk(mclk), .rst_b(rst_b), .go(go), .holdLen(holdLen), .timerIn(timerIn));
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    hiCyc <= hiCyc + int'(timerOut === 1'b1);
    if (timerIrq === 1'b1)
    begin
      irqQ.push_back(cyc);
      hiQ.push_back(hiCyc);
    end
    if (cyc > 2000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd, input logic [3:0] st);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, 24'h0, wd, st};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask : apb
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, {7'h0, i, 2'h0}, d, 4'hF);
  endtask : wr
  task automatic rdc(input string what, input logic [2:0] i, input logic [7:0] e);
    apb(1'b0, {7'h0, i, 2'h0}, 8'h00, 4'h0);
    chk(what, {24'h0, e}, rd);
  endtask : rdc
  task automatic load(input logic [7:0] c, input logic [7:0] p, input logic [7:0] r);
    logic [7:0] v [6];
    v = '{8'h00, c, 8'h00, r, 8'h00, p};
    for (int i = 0; i < 6; i++)
      wr(3'(i), v[i]);
    irqQ.delete();
    hiQ.delete();
  endtask : load
  task automatic wait_irqs(input int n);
    for (int k = 0; k < 400 && irqQ.size() < n; k++)
      @(posedge mclk);
    chk("irq count", n, irqQ.size());
  endtask : wait_irqs
  task automatic pulse(input logic [7:0] len);
    @(posedge mclk);
    {go, holdLen} <= {1'b1, len};
    @(posedge mclk);
    go <= 1'b0;
    repeat (len + 4) @(posedge mclk);
  endtask : pulse
  task automatic pwm_run(input logic pol, input logic [2:0] ex);
    wr(7, {1'b0, pol, ex, 3'h3});
    chk("idle level", pol, timerOut);
    load(8'h05, 8'h03, 8'h06);
    wr(7, {1'b1, pol, ex, 3'h3});
    enCyc = cyc;
    wait_irqs(3);
    chk("first pass", 2 << ex, irqQ[0] - enCyc);
    chk("period", 6 << ex, irqQ[2] - irqQ[1]);
    chk("high time", (pol ? 2 : 4) << ex, hiQ[2] - hiQ[1]);
    wr(7, {1'b0, pol, ex, 3'h3});
    $display("test pwm polarity %0d done", pol);
  endtask : pwm_run
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc("reset value", 3'(i), rv[i]);
    apb(1'b0, 12'h020, 8'h00, 4'h0);
    chk("unmapped error", 1'b1, err);
    apb(1'b1, 12'h00C, 8'h12, 4'h0);
    rdc("strobe off write", 3, 8'hFF);
    $display("test registers done");
    pwm_run(1'b0, 3'h0);
    pwm_run(1'b1, 3'h1);
    wr(7, 8'h44);
    load(8'h01, 8'h00, 8'h20);
    wr(7, 8'hC4);
    repeat (8) @(posedge mclk);
    pulse(3);
    wait_irqs(1);
    rdc("flag set", 6, 8'h02);
    wait_irqs(2);
    chk("count kept", 21, irqQ[1] - irqQ[0]);
    rdc("flag clear", 6, 8'h00);
    rdc("capture low", 5, 8'h0B);
    wr(7, 8'h44);
    wr(7, 8'h04);
    load(8'h01, 8'h00, 8'h20);
    wr(7, 8'h84);
    repeat (8) @(posedge mclk);
    pulse(3);
    wait_irqs(1);
    rdc("falling capture", 5, 8'h0E);
    wr(7, 8'h04);
    $display("test capture done");
    wr(7, 8'h06);
    load(8'h01, 8'h00, 8'h08);
    wr(7, 8'h86);
    pulse(4);
    wait_irqs(1);
    wr(6, 8'h18);
    pulse(2);
    pulse(3);
    wait_irqs(2);
    wr(7, 8'h06);
    rdc("gated count", 1, 8'h02);
    wr(6, 8'h10);
    load(8'h01, 8'h00, 8'h03);
    wr(7, 8'h86);
    pulse(4);
    wait_irqs(1);
    wr(7, 8'h06);
    rdc("deassert only count", 1, 8'h02);
    $display("test gated done");
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdc("reset again ctl0", 6, 8'h00);
    rdc("reset again ctl1", 7, 8'h00);
    rdc("reset again count", 1, 8'h01);
    $display("test second reset done");
    test_done();
  end
endmodule : timer_pwm_capture_gated_tb
